// ==== common/cldet_pkg.sv ====
// Purpose: Shared constants and types of the cold-load / inrush detector
// Assumes: 32-bit AHB-Lite register bus, byte offsets below
// Notes:   Currents are unsigned magnitudes in one common scale
package cldet_pkg;

   // ---------------------------------------------------------------
   // Widths and timing
   // ---------------------------------------------------------------
   localparam int CUR_W = 16;
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_TICK_CYC = CLK_HZ / MS_PER_S;
   localparam logic [15:0] WINDOW_MS = 16'h0050;
   localparam int HARM_PCT = 100;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_IDLE = 8'h04;
   localparam logic [7:0] OFS_PICKUP = 8'h08;
   localparam logic [7:0] OFS_HOLD = 8'h0C;
   localparam logic [7:0] OFS_F2THR = 8'h10;
   localparam logic [7:0] OFS_ROUTE = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFS_LARGEST = 8'h24;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic RST_EN = 1'h0;
   localparam logic [15:0] RST_IDLE = 16'h0100;
   localparam logic [15:0] RST_PICKUP = 16'h0400;
   localparam logic [15:0] RST_HOLD = 16'h03E8;
   localparam logic [7:0] RST_F2THR = 8'h0F;
   localparam logic [11:0] RST_ROUTE = 12'h00F;
   localparam logic [3:0] RST_MASK = 4'h0;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_EN = 0;
   localparam int RT_COLD_OUT = 0;
   localparam int RT_INR_OUT = 1;
   localparam int RT_COLD_BLK = 2;
   localparam int RT_INR_BLK = 3;
   localparam int RT_VOUT_COLD = 4;
   localparam int RT_VOUT_INR = 5;
   localparam int RT_ALT_LSB = 8;
   localparam int RT_BASE_LSB = 10;
   localparam int GRP_W = 2;
   localparam int EV_COLD = 0;
   localparam int EV_INR = 1;
   localparam int EV_MISS = 2;
   localparam int EV_END = 3;
   localparam int EV_W = 4;
   localparam int ST_ARMED = 0;
   localparam int ST_RISE = 1;
   localparam int ST_ACTIVE = 2;
   localparam int ST_COLD = 3;
   localparam int ST_INR = 4;
   localparam int ST_HARM = 5;

   typedef enum logic [1:0] {S_WAIT, S_ARMED, S_RISE, S_ACTIVE}
      cldet_state_e;

endpackage

// ==== common/cldet_meas_if.sv ====
// Purpose: Carries phase measurements to the magnitude evaluator
// Assumes: Three phases, magnitudes and second harmonic per phase
// Notes:   Evaluation results return on the same bundle
`timescale 1ns/1ps
interface cldet_meas_if #(parameter int W = cldet_pkg::CUR_W);
   logic [2:0][W-1:0] cur;
   logic [2:0][W-1:0] harm;
   logic [7:0] thr;
   logic [W-1:0] largest;
   logic harm_hit;

   modport src (output cur, output harm, output thr,
                input largest, input harm_hit);
   modport calc (input cur, input harm, input thr,
                 output largest, output harm_hit);
endinterface

// ==== hw/cldet_meas.sv ====
// Purpose: Largest phase magnitude and second-harmonic ratio check
// Assumes: Fundamental magnitude equals the phase current input
// Notes:   Purely combinational; ratio compared without division
`timescale 1ns/1ps
module cldet_meas #(
   parameter int W = cldet_pkg::CUR_W
) (
   cldet_meas_if.calc m
);
   localparam int PW = W + 8;

   logic [2:0] hit;
   logic [W-1:0] max_ab;

   // ---------------------------------------------------------------
   // Per phase ratio test: harm / cur > thr percent
   // ---------------------------------------------------------------
   for (genvar i = 0; i < 3; i++) begin : g_phase
      logic [PW-1:0] lhs;
      logic [PW-1:0] rhs;
      assign lhs = PW'(m.harm[i]) * PW'(cldet_pkg::HARM_PCT);
      assign rhs = PW'(m.cur[i]) * PW'(m.thr);
      assign hit[i] = lhs > rhs; // [R5]
   end

   assign m.harm_hit = |hit; // [R5]

   // Supervised quantity is the largest phase
   assign max_ab = (m.cur[0] > m.cur[1]) ? m.cur[0] : m.cur[1]; // [R7]
   assign m.largest = (max_ab > m.cur[2]) ? max_ab : m.cur[2]; // [R7]

endmodule // cldet_meas

// ==== hw/cldet_top.sv ====
// Purpose: Cold-load pick-up and inrush detector with AHB-Lite registers
// Assumes: Inputs synchronous to CLOCK; zero-wait bus slave
// Notes:   CE low freezes all state, bus included; drop it only when idle
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps

// Function
// [R1] Cold load needs all phases below idle, then one above pick-up in 80 ms.
// [R2] A recognised cold load drives the cold-load output for the hold time.
// [R3] Cold-load and inrush outputs feed both output and blocking matrices.
// [R4] The outputs can select the setting group through virtual outputs.
// [R5] Inrush also needs one phase's second-harmonic ratio above threshold.
// [R6] A zero second-harmonic threshold makes inrush follow cold load.
// [R7] Pick-up is compared against the largest of the three phase currents.
// [R8] Current between idle and pick-up for over 80 ms gives no cold load.
// [R9] Cold load lasts the hold time or while current stays above pick-up.
// [R10] After an output ends, all phases must fall below idle to re-arm.
module cldet_top #(
   parameter int TICK_CYC = cldet_pkg::MS_TICK_CYC,
   parameter int W = cldet_pkg::CUR_W
) (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [W-1:0] PHASE_A_CURRENT,
   input wire logic [W-1:0] PHASE_B_CURRENT,
   input wire logic [W-1:0] PHASE_C_CURRENT,
   input wire logic [W-1:0] PHASE_A_SECOND,
   input wire logic [W-1:0] PHASE_B_SECOND,
   input wire logic [W-1:0] PHASE_C_SECOND,
   output logic COLD_START_FLAG,
   output logic INRUSH_FLAG,
   output logic OUTMTX_COLD,
   output logic OUTMTX_INRUSH,
   output logic BLKMTX_COLD,
   output logic BLKMTX_INRUSH,
   output logic [1:0] SETTING_GROUP,
   output logic IRQ
);
   localparam int CYC_W = $clog2(TICK_CYC + 1);

   cldet_pkg::cldet_state_e st_q, st_d;
   logic ctrl_en_q;
   logic [W-1:0] idle_q, pickup_q;
   logic [15:0] hold_q, ms_q;
   logic [7:0] thr_q;
   logic [11:0] route_q;
   logic [3:0] stat_q, mask_q, ev, w1c;
   logic [CYC_W-1:0] cyc_q;
   logic cold_q, inr_q, cold_d, inr_d;
   logic outm_cold_q, outm_inr_q, blk_cold_q, blk_inr_q, irq_q;
   logic [1:0] grp_q, alt_grp;
   logic idle, above, win_out, hold_done, thr_zero, inr_ok;
   logic vsel, end_ok, zero_ce;
   logic take, wr_pend_q, wr_ok;
   logic [7:0] wr_addr_q;
   logic [31:0] rdata_q, rd_mux;

   // ---------------------------------------------------------------
   // Measurement evaluation
   // ---------------------------------------------------------------
   cldet_meas_if #(.W(W)) meas ();

   assign meas.cur = {PHASE_C_CURRENT, PHASE_B_CURRENT, PHASE_A_CURRENT};
   assign meas.harm = {PHASE_C_SECOND, PHASE_B_SECOND, PHASE_A_SECOND};
   assign meas.thr = thr_q;

   cldet_meas #(.W(W)) u_meas (
      .m(meas.calc)
   );

   assign idle = meas.largest < idle_q;
   assign above = meas.largest > pickup_q; // [R7]
   assign win_out = ms_q >= cldet_pkg::WINDOW_MS;
   assign hold_done = ms_q >= hold_q;
   assign thr_zero = thr_q == 8'h00;
   assign inr_ok = thr_zero | meas.harm_hit; // [R6]
   assign end_ok = (hold_done & ~above) | ~ctrl_en_q;
   assign zero_ce = thr_zero & CE;

   // ---------------------------------------------------------------
   // Detection sequence
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         cldet_pkg::S_WAIT: begin
            if (idle) begin // [R10]
               st_d = cldet_pkg::S_ARMED;
            end
         end
         cldet_pkg::S_ARMED: begin
            if (above) begin // [R1]
               st_d = cldet_pkg::S_ACTIVE;
            end else if (!idle) begin
               st_d = cldet_pkg::S_RISE;
            end
         end
         cldet_pkg::S_RISE: begin
            if (above) begin // [R1]
               st_d = cldet_pkg::S_ACTIVE;
            end else if (idle) begin
               st_d = cldet_pkg::S_ARMED;
            end else if (win_out) begin // [R8]
               st_d = cldet_pkg::S_WAIT;
            end
         end
         cldet_pkg::S_ACTIVE: begin
            // Ends once hold time is spent and current has fallen, or at once when ctrl_en_q is cleared
            if (hold_done && !above) begin // [R2] [R9]
               st_d = cldet_pkg::S_WAIT; // [R10]
            end
         end
         default: st_d = cldet_pkg::S_WAIT;
      endcase
      if (!ctrl_en_q) begin
         st_d = cldet_pkg::S_WAIT;
      end
   end

   assign cold_d = st_d == cldet_pkg::S_ACTIVE; // [R2]
   assign inr_d = cold_d & inr_ok; // [R5] [R6]

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         st_q <= cldet_pkg::S_WAIT;
         cold_q <= 1'b0;
         inr_q <= 1'b0;
      end else if (CE) begin
         st_q <= st_d;
         cold_q <= cold_d;
         inr_q <= inr_d;
      end
   end

   // Shared millisecond timer, restarted on every state change so the
   // window and hold both start exactly at their entry edge
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         cyc_q <= '0;
         ms_q <= 16'h0000;
      end else if (CE) begin
         if (st_d != st_q) begin
            cyc_q <= '0;
            ms_q <= 16'h0000;
         end else if (cyc_q == CYC_W'(TICK_CYC - 1)) begin
            cyc_q <= '0;
            if (ms_q != 16'hFFFF) begin
               ms_q <= ms_q + 16'h0001;
            end
         end else begin
            cyc_q <= cyc_q + CYC_W'(1);
         end
      end
   end

   // ---------------------------------------------------------------
   // Matrix routing and setting-group selection
   // ---------------------------------------------------------------
   assign vsel = (cold_q & route_q[cldet_pkg::RT_VOUT_COLD])
               | (inr_q & route_q[cldet_pkg::RT_VOUT_INR]);
   assign alt_grp = vsel
      ? route_q[cldet_pkg::RT_ALT_LSB +: cldet_pkg::GRP_W]
      : route_q[cldet_pkg::RT_BASE_LSB +: cldet_pkg::GRP_W];

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         outm_cold_q <= 1'b0;
         outm_inr_q <= 1'b0;
         blk_cold_q <= 1'b0;
         blk_inr_q <= 1'b0;
         grp_q <= 2'h0;
      end else if (CE) begin
         outm_cold_q <= cold_q & route_q[cldet_pkg::RT_COLD_OUT]; // [R3]
         outm_inr_q <= inr_q & route_q[cldet_pkg::RT_INR_OUT]; // [R3]
         blk_cold_q <= cold_q & route_q[cldet_pkg::RT_COLD_BLK]; // [R3]
         blk_inr_q <= inr_q & route_q[cldet_pkg::RT_INR_BLK]; // [R3]
         grp_q <= alt_grp; // [R4]
      end
   end

   // ---------------------------------------------------------------
   // Events and interrupt
   // ---------------------------------------------------------------
   assign ev[cldet_pkg::EV_COLD] = cold_d & ~cold_q;
   assign ev[cldet_pkg::EV_INR] = inr_d & ~inr_q;
   assign ev[cldet_pkg::EV_MISS] = ctrl_en_q & win_out & ~above & ~idle
                                 & (st_q == cldet_pkg::S_RISE);
   assign ev[cldet_pkg::EV_END] = ~cold_d & cold_q;

   assign w1c = (wr_ok && wr_addr_q == cldet_pkg::OFS_IRQ_STAT)
              ? HWDATA[cldet_pkg::EV_W-1:0] : 4'h0;

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         stat_q <= 4'h0;
         irq_q <= 1'b0;
      end else if (CE) begin
         // A new event beats a simultaneous clear
         stat_q <= (stat_q & ~w1c) | ev;
         irq_q <= |(stat_q & mask_q);
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------------------------
   assign take = HSEL & HTRANS[1] & HREADY;
   assign wr_ok = wr_pend_q;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (HADDR[7:0])
         cldet_pkg::OFS_CTRL: rd_mux[cldet_pkg::CTRL_EN] = ctrl_en_q;
         cldet_pkg::OFS_IDLE: rd_mux[W-1:0] = idle_q;
         cldet_pkg::OFS_PICKUP: rd_mux[W-1:0] = pickup_q;
         cldet_pkg::OFS_HOLD: rd_mux[15:0] = hold_q;
         cldet_pkg::OFS_F2THR: rd_mux[7:0] = thr_q;
         cldet_pkg::OFS_ROUTE: rd_mux[11:0] = route_q;
         cldet_pkg::OFS_STATUS: begin
            rd_mux[cldet_pkg::ST_ARMED] = st_q == cldet_pkg::S_ARMED;
            rd_mux[cldet_pkg::ST_RISE] = st_q == cldet_pkg::S_RISE;
            rd_mux[cldet_pkg::ST_ACTIVE] = st_q == cldet_pkg::S_ACTIVE;
            rd_mux[cldet_pkg::ST_COLD] = cold_q;
            rd_mux[cldet_pkg::ST_INR] = inr_q;
            rd_mux[cldet_pkg::ST_HARM] = meas.harm_hit;
         end
         cldet_pkg::OFS_IRQ_STAT: rd_mux[3:0] = stat_q;
         cldet_pkg::OFS_IRQ_MASK: rd_mux[3:0] = mask_q;
         cldet_pkg::OFS_LARGEST: rd_mux[W-1:0] = meas.largest;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else if (CE) begin
         wr_pend_q <= take & HWRITE & (HSIZE == 3'h2);
         wr_addr_q <= HADDR[7:0];
         rdata_q <= (take & ~HWRITE) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         ctrl_en_q <= cldet_pkg::RST_EN;
         idle_q <= W'(cldet_pkg::RST_IDLE);
         pickup_q <= W'(cldet_pkg::RST_PICKUP);
         hold_q <= cldet_pkg::RST_HOLD;
         thr_q <= cldet_pkg::RST_F2THR;
         route_q <= cldet_pkg::RST_ROUTE;
         mask_q <= cldet_pkg::RST_MASK;
      end else if (CE && wr_ok) begin
         case (wr_addr_q)
            cldet_pkg::OFS_CTRL: ctrl_en_q <= HWDATA[cldet_pkg::CTRL_EN];
            cldet_pkg::OFS_IDLE: idle_q <= HWDATA[W-1:0];
            cldet_pkg::OFS_PICKUP: pickup_q <= HWDATA[W-1:0];
            cldet_pkg::OFS_HOLD: hold_q <= HWDATA[15:0];
            cldet_pkg::OFS_F2THR: thr_q <= HWDATA[7:0];
            cldet_pkg::OFS_ROUTE: route_q <= HWDATA[11:0];
            cldet_pkg::OFS_IRQ_MASK: mask_q <= HWDATA[3:0];
            default: ;
         endcase
      end
   end

   assign HRDATA = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign COLD_START_FLAG = cold_q;
   assign INRUSH_FLAG = inr_q;
   assign OUTMTX_COLD = outm_cold_q;
   assign OUTMTX_INRUSH = outm_inr_q;
   assign BLKMTX_COLD = blk_cold_q;
   assign BLKMTX_INRUSH = blk_inr_q;
   assign SETTING_GROUP = grp_q;
   assign IRQ = irq_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   AST_COLD_AFTER_ARM: assert property ( // [R1]
      $rose(cold_q) |-> ($past(st_q) == cldet_pkg::S_ARMED
                         || $past(st_q) == cldet_pkg::S_RISE))
      else $error("cold load without idle arming");
   AST_WINDOW_BOUND: assert property ( // [R1]
      st_q == cldet_pkg::S_RISE |-> ms_q <= cldet_pkg::WINDOW_MS)
      else $error("transition window overran");
   AST_HOLD_KEEPS: assert property ( // [R2]
      (CE && ctrl_en_q && cold_q && !hold_done) |=> cold_q)
      else $error("cold load dropped before hold time");
   AST_END_CAUSE: assert property ( // [R9]
      $fell(cold_q) |-> $past(end_ok))
      else $error("cold load ended while current above pick-up");
   AST_ROUTE_ON: assert property ( // [R3]
      (CE && cold_q && route_q[cldet_pkg::RT_COLD_OUT]
       && route_q[cldet_pkg::RT_COLD_BLK]) |=> (outm_cold_q && blk_cold_q))
      else $error("cold load not routed to both matrices");
   AST_ROUTE_OFF: assert property ( // [R3]
      (CE && !inr_q && !cold_q) |=> !(outm_inr_q || blk_inr_q
                                      || outm_cold_q || blk_cold_q))
      else $error("matrix output without detection");
   AST_GROUP_SEL: assert property ( // [R4]
      (CE && cold_q && route_q[cldet_pkg::RT_VOUT_COLD])
      |=> grp_q == $past(route_q[cldet_pkg::RT_ALT_LSB +: cldet_pkg::GRP_W]))
      else $error("setting group not taken from virtual output");
   AST_INR_NEEDS_COLD: assert property ( // [R5]
      inr_q |-> cold_q)
      else $error("inrush without cold load sequence");
   AST_INR_NEEDS_HARM: assert property ( // [R5]
      $rose(inr_q) |-> $past(inr_ok))
      else $error("inrush without harmonic content");
   AST_ZERO_THR: assert property ( // [R6]
      $past(zero_ce) |-> inr_q == cold_q)
      else $error("inrush differs from cold load at zero threshold");
   AST_PICKUP_MAX: assert property ( // [R7]
      (CE && ctrl_en_q && st_q == cldet_pkg::S_ARMED
       && meas.largest > pickup_q) |=> cold_q)
      else $error("largest phase above pick-up not detected");
   AST_LINGER_MISS: assert property ( // [R8]
      (CE && ev[cldet_pkg::EV_MISS]) |=> (st_q == cldet_pkg::S_WAIT
                                          && !cold_q))
      else $error("late rise still declared");
   AST_REARM_IDLE: assert property ( // [R10]
      (CE && st_q == cldet_pkg::S_WAIT && !idle) |=> (!cold_q
                                          && st_q == cldet_pkg::S_WAIT))
      else $error("re-armed without idle current");

   COV_COLD: cover property ($rose(cold_q));
   COV_INRUSH: cover property ($rose(inr_q));
   COV_MISS: cover property (st_q == cldet_pkg::S_RISE
                             ##1 st_q == cldet_pkg::S_WAIT);
   COV_END: cover property ($fell(cold_q) ##1 st_q == cldet_pkg::S_ARMED);

endmodule // cldet_top

// ==== testbench/cldet_mtx_model.sv ====
// Purpose: Output matrix and blocking matrix stand-in at the far side
// Assumes: Routed flags arrive as registered levels on CLOCK
// Notes:   Only records what arrives; it never answers back
`timescale 1ns/1ps
module cldet_mtx_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic out_cold,
   input wire logic out_inrush,
   input wire logic blk_cold,
   input wire logic blk_inrush,
   input wire logic [1:0] group,
   output logic relay_q,
   output logic blocked_q,
   output logic [1:0] group_q
);
   // ---------------------------------------------------------------
   // Matrix outputs
   // ---------------------------------------------------------------
   // One flop of delay, as a real relay matrix latches once per cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         relay_q <= 1'b0;
         blocked_q <= 1'b0;
         group_q <= 2'h0;
      end else begin
         relay_q <= out_cold | out_inrush;
         blocked_q <= blk_cold | blk_inrush;
         group_q <= group;
      end
   end
endmodule // cldet_mtx_model

// ==== testbench/cldet_top_tb.sv ====
// Purpose: Self-checking bench of the cold-load / inrush detector
// Assumes: One slave on the bus, so HREADY is tied to HREADYOUT
// Notes:   Millisecond tick shortened to 10 cycles to keep runs short
`timescale 1ns/1ps
module cldet_top_tb;
   localparam int TICK = 10;
   logic CLOCK;
   logic RST_B;
   logic HSEL;
   logic HWRITE;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [31:0] HADDR;
   logic [31:0] HWDATA;
   logic [31:0] HRDATA;
   logic HREADYOUT;
   logic HRESP;
   logic ce;
   logic [15:0] cur_a, cur_b, cur_c, sec_a, sec_b, sec_c;
   logic cold, inr, om_c, om_i, bm_c, bm_i, irq, relay, blocked;
   logic [1:0] grp;
   logic [1:0] grp_seen;
   int miscompares = 0;
   int num_checks = 0;

   cldet_top #(.TICK_CYC(TICK)) dut (
      .CLOCK(CLOCK), .RST_B(RST_B), .CE(ce), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .PHASE_A_CURRENT(cur_a), .PHASE_B_CURRENT(cur_b),
      .PHASE_C_CURRENT(cur_c), .PHASE_A_SECOND(sec_a),
      .PHASE_B_SECOND(sec_b), .PHASE_C_SECOND(sec_c),
      .COLD_START_FLAG(cold), .INRUSH_FLAG(inr), .OUTMTX_COLD(om_c),
      .OUTMTX_INRUSH(om_i), .BLKMTX_COLD(bm_c), .BLKMTX_INRUSH(bm_i),
      .SETTING_GROUP(grp), .IRQ(irq));

   cldet_mtx_model mtx (
      .clock(CLOCK), .rst_b(RST_B), .out_cold(om_c), .out_inrush(om_i),
      .blk_cold(bm_c), .blk_inrush(bm_i), .group(grp),
      .relay_q(relay), .blocked_q(blocked), .group_q(grp_seen));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h", $time, msg, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
   endtask

   // Single word transfer; the hold on each phase ends only on HREADY
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge CLOCK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {24'h000000, a};
      HSIZE <= 3'h2;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
      chk({31'h0, HRESP}, 32'h0, "error response");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                      input string msg);
      logic [31:0] d;
      bus(1'b0, a, 32'h00000000, d);
      chk(d, exp, msg);
   endtask

   task automatic set_cur(input logic [15:0] a, input logic [15:0] b,
                          input logic [15:0] c);
      cur_a <= a;
      cur_b <= b;
      cur_c <= c;
   endtask

   task automatic arm();
      set_cur(16'h0000, 16'h0000, 16'h0000);
      cyc(5);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      rdc(cldet_pkg::OFS_CTRL, 32'h00000000, "ctrl reset");
      rdc(cldet_pkg::OFS_IDLE, 32'h00000100, "idle reset");
      rdc(cldet_pkg::OFS_PICKUP, 32'h00000400, "pickup reset");
      rdc(cldet_pkg::OFS_HOLD, 32'h000003E8, "hold reset");
      rdc(cldet_pkg::OFS_F2THR, 32'h0000000F, "ratio reset");
      rdc(cldet_pkg::OFS_ROUTE, 32'h0000000F, "route reset");
      rdc(cldet_pkg::OFS_IRQ_MASK, 32'h00000000, "mask reset");
      wr(cldet_pkg::OFS_LARGEST, 32'h0000FFFF);
      rdc(cldet_pkg::OFS_LARGEST, 32'h00000000, "largest is ro");
      rdc(8'h28, 32'h00000000, "unmapped read");
      chk({30'h0, grp}, 32'h0, "group after reset");
   endtask

   // Plain cold load on phase B only, held past the hold time by current
   task automatic t_cold();
      wr(cldet_pkg::OFS_ROUTE, 32'h0000061F);
      wr(cldet_pkg::OFS_IRQ_MASK, 32'h0000000F);
      wr(cldet_pkg::OFS_HOLD, 32'h00000005);
      wr(cldet_pkg::OFS_CTRL, 32'h00000001);
      arm();
      set_cur(16'h0010, 16'h0500, 16'h0020);
      // Matrix model adds one more flop behind the routed outputs
      cyc(4);
      chk({31'h0, cold}, 32'h1, "cold not raised");
      chk({31'h0, inr}, 32'h0, "inrush without harmonic");
      chk({28'h0, om_c, bm_c, relay, blocked}, 32'hF, "cold routing");
      chk({30'h0, grp}, 32'h2, "alt group");
      chk({30'h0, grp_seen}, 32'h2, "group at matrix");
      chk({31'h0, irq}, 32'h1, "irq on cold");
      rdc(cldet_pkg::OFS_LARGEST, 32'h00000500, "largest phase");
      rdc(cldet_pkg::OFS_STATUS, 32'h0000000C, "status active");
      cyc(100);
      chk({31'h0, cold}, 32'h1, "cold dropped above pickup");
      set_cur(16'h0000, 16'h0200, 16'h0000);
      cyc(4);
      chk({31'h0, cold}, 32'h0, "cold outlived hold");
      chk({30'h0, grp}, 32'h1, "base group");
      set_cur(16'h0000, 16'h0500, 16'h0000);
      cyc(5);
      chk({31'h0, cold}, 32'h0, "rearmed without idle");
      rdc(cldet_pkg::OFS_IRQ_STAT, 32'h00000009, "cold events");
      wr(cldet_pkg::OFS_IRQ_STAT, 32'h0000000F);
      cyc(2);
      chk({31'h0, irq}, 32'h0, "irq not cleared");
      rdc(cldet_pkg::OFS_IRQ_STAT, 32'h00000000, "stat not cleared");
   endtask

   // Harmonic ratio 0x100*100 above 0x500*15; hold of 5 ms is 50 cycles
   task automatic t_inrush();
      arm();
      sec_a <= 16'h0100;
      set_cur(16'h0500, 16'h0000, 16'h0000);
      cyc(3);
      chk({30'h0, cold, inr}, 32'h3, "inrush not raised");
      chk({30'h0, om_i, bm_i}, 32'h3, "inrush routing");
      set_cur(16'h0200, 16'h0000, 16'h0000);
      cyc(40);
      chk({31'h0, cold}, 32'h1, "cold shorter than hold");
      cyc(25);
      chk({31'h0, cold}, 32'h0, "cold longer than hold");
      sec_a <= 16'h0000;
   endtask

   // Zero ratio threshold, routing and mask all off
   task automatic t_f2zero();
      wr(cldet_pkg::OFS_F2THR, 32'h00000000);
      wr(cldet_pkg::OFS_ROUTE, 32'h00000400);
      wr(cldet_pkg::OFS_IRQ_MASK, 32'h00000000);
      wr(cldet_pkg::OFS_IRQ_STAT, 32'h0000000F);
      arm();
      // Clock enable low must freeze the armed detector
      ce <= 1'b0;
      set_cur(16'h0000, 16'h0000, 16'h0500);
      cyc(4);
      chk({30'h0, cold, inr}, 32'h0, "moved with clock enable low");
      ce <= 1'b1;
      cyc(3);
      chk({30'h0, cold, inr}, 32'h3, "inrush differs from cold");
      chk({28'h0, om_c, om_i, bm_c, bm_i}, 32'h0, "unrouted flags");
      chk({30'h0, grp}, 32'h1, "group without virtual out");
      chk({31'h0, irq}, 32'h0, "masked irq");
      set_cur(16'h0000, 16'h0000, 16'h0000);
      cyc(60);
      chk({30'h0, cold, inr}, 32'h0, "flags stuck");
   endtask

   // Transition window of 80 ms is 800 cycles
   task automatic t_window();
      set_cur(16'h0200, 16'h0000, 16'h0000);
      cyc(400);
      set_cur(16'h0500, 16'h0000, 16'h0000);
      cyc(3);
      chk({31'h0, cold}, 32'h1, "rise inside window");
      set_cur(16'h0000, 16'h0000, 16'h0000);
      cyc(60);
      wr(cldet_pkg::OFS_IRQ_STAT, 32'h0000000F);
      cyc(3);
      set_cur(16'h0200, 16'h0000, 16'h0000);
      cyc(850);
      set_cur(16'h0500, 16'h0000, 16'h0000);
      cyc(3);
      chk({31'h0, cold}, 32'h0, "rise after window");
      rdc(cldet_pkg::OFS_IRQ_STAT, 32'h00000004, "window miss");
   endtask

   // ---------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end

   initial begin
      RST_B = 1'b0;
      ce = 1'b1;
      HSEL = 1'b0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HADDR = 32'h00000000;
      HSIZE = 3'h2;
      HWDATA = 32'h00000000;
      {cur_a, cur_b, cur_c} = '0;
      {sec_a, sec_b, sec_c} = '0;
      cyc(5);
      RST_B <= 1'b1;
      t_regs();
      t_cold();
      t_inrush();
      t_f2zero();
      t_window();
      stop_test();
   end

   // About 1700 cycles are needed; allow about twelve times that
   initial begin
      #(20000 * 50);
      miscompares++;
      stop_test();
   end
endmodule // cldet_top_tb
